// ### include/acc_pkg.sv
package acc_pkg;
    // ********************
    // Register map
    // ********************
    localparam int         ADDR_W       = 3;
    localparam logic [2:0] OFS_CLK_CTRL = 3'h0;
    localparam logic [2:0] OFS_RUN_CTRL = 3'h1;
    localparam logic [2:0] OFS_PIN_CFG  = 3'h2;
    localparam logic [2:0] OFS_RES_LO   = 3'h3;
    localparam logic [2:0] OFS_RES_HI   = 3'h4;
    localparam logic [2:0] OFS_IRQ_CTRL = 3'h5;
    // ********************
    // Fields and resets
    // ********************
    localparam int         DIV_LSB      = 0;
    localparam int         REF_BIT      = 3;
    localparam int         PWR_OFF_BIT  = 7;
    localparam int         BUSY_BIT     = 6;
    localparam int         START_BIT    = 7;
    localparam int         FLAG_BIT     = 0;
    localparam int         CIE_BIT      = 1;
    localparam int         MFE_BIT      = 2;
    localparam int         GIE_BIT      = 3;
    localparam logic [2:0] RST_DIV      = 3'h0;
    localparam logic [7:0] RST_PIN_CFG  = 8'h00;
    localparam logic [3:0] RST_CHANNEL  = 4'h0;
    // ********************
    // Conversion timing
    // ********************
    localparam int         RES_W        = 12;
    localparam int         CONV_TAD     = 16;
    localparam int         SAMPLE_TAD   = 3;
endpackage : acc_pkg

// ### include/acc_conv_if.sv
`timescale 1ns/1ps
interface acc_conv_if;
    import acc_pkg::*;
    logic             go;
    logic             abort;
    logic [2:0]       div_sel;
    logic             tad_en;
    logic             cmp_above;
    logic             running;
    logic             done;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] result;
    modport ctl (output go, abort, div_sel, cmp_above,
                 input running, done, trial, result);
    modport div (input go, div_sel, output tad_en);
    modport eng (input go, abort, tad_en, cmp_above,
                 output running, done, trial, result);
endinterface : acc_conv_if

// ### core/acc_clk_div.sv
`timescale 1ns/1ps
module acc_clk_div
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Engine side
    acc_conv_if.div  bus
);
    logic [4:0] cnt;
    logic [4:0] ratio_m1;
    logic [4:0] gap;
    logic [2:0] tick_shift;

    always_comb begin
        case (bus.div_sel)
            3'h4:    ratio_m1 = 5'h00;
            3'h0:    ratio_m1 = 5'h01;
            3'h5:    ratio_m1 = 5'h03;
            3'h1:    ratio_m1 = 5'h07;
            3'h6:    ratio_m1 = 5'h0f;
            default: ratio_m1 = 5'h1f;
        endcase
    end

    // Helper: spacing as a power of two, apart from the counter table
    always_comb begin
        case (bus.div_sel)
            3'h4:    tick_shift = 3'h0;
            3'h0:    tick_shift = 3'h1;
            3'h5:    tick_shift = 3'h2;
            3'h1:    tick_shift = 3'h3;
            3'h6:    tick_shift = 3'h4;
            default: tick_shift = 3'h5;
        endcase
    end

    assign bus.tad_en = (cnt == ratio_m1);

    // Restart on go so the first period is whole
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 5'h00;
        end else if (bus.go || bus.tad_en) begin
            cnt <= 5'h00;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap <= 5'h00;
        end else if (bus.go || bus.tad_en) begin
            gap <= 5'h00;
        end else begin
            gap <= gap + 5'h01;
        end
    end

    chk_tick_spacing: assert property (@(posedge clk) disable iff (rst)
        bus.tad_en && !$past(bus.go) && !$past(bus.tad_en)
            |-> gap == 5'((6'h01 << tick_shift) - 6'h01))
        else $error("converter clock tick spacing wrong");
endmodule : acc_clk_div

// ### core/acc_sar.sv
`timescale 1ns/1ps
module acc_sar
    import acc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control side
    acc_conv_if.eng  bus
);
    localparam logic [3:0]       LAST_STEP   = 4'(CONV_TAD - 1);
    localparam logic [3:0]       SAMPLE_STEP = 4'(SAMPLE_TAD - 1);
    localparam logic [RES_W-1:0] MSB_ONE     = {1'b1, {(RES_W-1){1'b0}}};

    logic [3:0]       step;
    logic [RES_W-1:0] probe;
    logic [4:0]       ticks;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.running <= 1'b0;
            bus.done    <= 1'b0;
            bus.trial   <= '0;
            bus.result  <= '0;
            step        <= 4'h0;
            probe       <= '0;
        end else begin
            bus.done <= 1'b0;
            if (bus.abort) begin
                bus.running <= 1'b0;
                bus.trial   <= '0;
                probe       <= '0;
            end else if (bus.go) begin
                bus.running <= 1'b1;
                bus.trial   <= '0;
                step        <= 4'h0;
                probe       <= '0;
            end else if (bus.running && bus.tad_en) begin
                step <= step + 4'h1;
                if (step == LAST_STEP) begin
                    bus.result  <= bus.trial;
                    bus.done    <= 1'b1;
                    bus.running <= 1'b0;
                end else if (step == SAMPLE_STEP) begin
                    bus.trial <= MSB_ONE;
                    probe     <= MSB_ONE;
                end else if (probe != '0) begin
                    bus.trial <= (bus.cmp_above ? bus.trial
                                 : bus.trial & ~probe) | (probe >> 1);
                    probe     <= probe >> 1;
                end
            end
        end
    end

    // Helper: ticks seen since go
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ticks <= 5'h00;
        end else if (bus.go) begin
            ticks <= 5'h00;
        end else if (bus.running && bus.tad_en) begin
            ticks <= ticks + 5'h01;
        end
    end

    chk_conv_length: assert property (@(posedge clk) disable iff (rst)
        bus.done |-> ticks == 5'(CONV_TAD))
        else $error("conversion did not take sixteen periods");
endmodule : acc_sar

// ### core/acc_top.sv
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output      logic [7:0]        reg_rdata,
    // Analog front end
    input  wire logic              cmp_above,
    output      logic [RES_W-1:0]  dac_code,
    output      logic [3:0]        channel_select,
    output      logic              reference_select,
    output      logic              converter_power_off,
    output      logic [7:0]        pin_analog_enable,
    // Interrupt controller
    input  wire logic              stack_full,
    output      logic              irq_request
);
    // ********************
    // Register state
    // ********************
    logic [2:0]       clock_divider_select;
    logic             start_bit;
    logic             conversion_busy_n;
    logic [7:0]       result_low_byte;
    logic [7:0]       result_high_byte;
    logic             converter_irq_flag;
    logic             converter_irq_enable;
    logic             multifunction_irq_enable;
    logic             global_irq_enable;
    logic             next_irq_flag;
    logic             wr_clk;
    logic             wr_run;
    logic             wr_pin;
    logic             wr_irq;
    logic             start_rise;
    logic             start_fall;

    acc_conv_if conv ();

    assign wr_clk = reg_we && (reg_addr == OFS_CLK_CTRL);
    assign wr_run = reg_we && (reg_addr == OFS_RUN_CTRL);
    assign wr_pin = reg_we && (reg_addr == OFS_PIN_CFG);
    assign wr_irq = reg_we && (reg_addr == OFS_IRQ_CTRL);

    // ********************
    // Clock control
    // ********************
    // divider, reference, power
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_divider_select <= RST_DIV;
            reference_select     <= 1'b0;
            converter_power_off  <= 1'b1;
        end else if (wr_clk) begin
            clock_divider_select <= reg_wdata[DIV_LSB +: 3];
            reference_select     <= reg_wdata[REF_BIT];
            converter_power_off  <= reg_wdata[PWR_OFF_BIT];
        end
    end

    // ********************
    // Run control
    // ********************
    // channel routing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            channel_select <= RST_CHANNEL;
        end else if (wr_run) begin
            channel_select <= reg_wdata[3:0];
        end
    end

    // ********************
    // Start control
    // ********************
    // start edge detection
    assign start_rise = wr_run && reg_wdata[START_BIT] && !start_bit;
    assign start_fall = wr_run && !reg_wdata[START_BIT] && start_bit;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            start_bit <= 1'b0;
        end else if (wr_run) begin
            start_bit <= reg_wdata[START_BIT];
        end
    end

    // Rising edge resets the engine, falling edge launches it
    assign conv.div_sel   = clock_divider_select;
    assign conv.cmp_above = cmp_above;
    assign conv.abort     = converter_power_off || start_rise;
    assign conv.go        = start_fall && !converter_power_off;

    acc_clk_div u_div (
        .clk (clk),
        .rst (rst),
        .bus (conv)
    );

    acc_sar u_sar (
        .clk (clk),
        .rst (rst),
        .bus (conv)
    );

    assign dac_code   = conv.trial;

    // ********************
    // Busy flag
    // ********************
    // busy while converting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conversion_busy_n <= 1'b1;
        end else if (conv.done) begin
            conversion_busy_n <= 1'b0;
        end else if ((start_rise && !converter_power_off) || conv.go) begin
            // Launch raises busy too: the rise may have come while off
            conversion_busy_n <= 1'b1;
        end
    end

    // ********************
    // Result bytes
    // ********************
    // result capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_low_byte  <= 8'h00;
            result_high_byte <= 8'h00;
        end else if (conv.done) begin
            result_low_byte  <= conv.result[7:0];
            result_high_byte <= {4'h0, conv.result[RES_W-1:8]};
        end
    end

    // ********************
    // Pin configuration
    // ********************
    // analog pin enables
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_analog_enable <= RST_PIN_CFG;
        end else if (wr_pin) begin
            pin_analog_enable <= reg_wdata;
        end
    end

    // ********************
    // Interrupt request
    // ********************
    // set beats software clear
    always_comb begin
        next_irq_flag = converter_irq_flag;
        if (wr_irq) begin
            next_irq_flag = reg_wdata[FLAG_BIT];
        end
        if (conv.done) begin
            next_irq_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_irq_flag <= 1'b0;
        end else begin
            converter_irq_flag <= next_irq_flag;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_irq_enable     <= 1'b0;
            multifunction_irq_enable <= 1'b0;
            global_irq_enable        <= 1'b0;
        end else if (wr_irq) begin
            converter_irq_enable     <= reg_wdata[CIE_BIT];
            multifunction_irq_enable <= reg_wdata[MFE_BIT];
            global_irq_enable        <= reg_wdata[GIE_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= converter_irq_flag && converter_irq_enable
                        && multifunction_irq_enable && global_irq_enable
                        && !stack_full;
        end
    end

    // ********************
    // Read port
    // ********************
    // Unmapped offsets read zero so software sees no stale data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_re) begin
            case (reg_addr)
                OFS_CLK_CTRL: begin
                    reg_rdata <= {converter_power_off, 3'h0,
                                  reference_select, clock_divider_select};
                end
                OFS_RUN_CTRL: begin
                    reg_rdata <= {start_bit, conversion_busy_n, 2'h0,
                                  channel_select};
                end
                OFS_PIN_CFG: begin
                    reg_rdata <= pin_analog_enable;
                end
                OFS_RES_LO: begin
                    reg_rdata <= result_low_byte;
                end
                OFS_RES_HI: begin
                    reg_rdata <= result_high_byte;
                end
                OFS_IRQ_CTRL: begin
                    reg_rdata <= {4'h0, global_irq_enable,
                                  multifunction_irq_enable,
                                  converter_irq_enable, converter_irq_flag};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ********************
    // Checks
    // ********************
    chk_busy_at_start: assert property (@(posedge clk) disable iff (rst)
        start_rise && !converter_power_off |=> conversion_busy_n
            ##1 conversion_busy_n)
        else $error("busy did not rise at start");

    chk_busy_falls: assert property (@(posedge clk) disable iff (rst)
        conv.done |=> !conversion_busy_n)
        else $error("busy still high after completion");

    chk_result_load: assert property (@(posedge clk) disable iff (rst)
        conv.done |=> {result_high_byte[3:0], result_low_byte}
            == $past(conv.result) && result_high_byte[7:4] == 4'h0)
        else $error("result bytes not loaded on completion");

    chk_flag_set: assert property (@(posedge clk) disable iff (rst)
        conv.done |=> converter_irq_flag)
        else $error("completion did not set interrupt flag");

    chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
        irq_request |-> $past(global_irq_enable) &&
            $past(multifunction_irq_enable) && $past(converter_irq_enable)
            && $past(converter_irq_flag))
        else $error("interrupt raised without all enables");

    chk_stack_block: assert property (@(posedge clk) disable iff (rst)
        stack_full |=> !irq_request)
        else $error("interrupt raised while stack full");

    chk_power_idle: assert property (@(posedge clk) disable iff (rst)
        converter_power_off |=> !conv.running && dac_code == '0)
        else $error("converter active while powered off");

    chk_start_launch: assert property (@(posedge clk) disable iff (rst)
        start_fall && !converter_power_off |=> conv.running)
        else $error("falling start did not launch conversion");

    chk_abort_rise: assert property (@(posedge clk) disable iff (rst)
        start_rise |=> !conv.running)
        else $error("rising start did not stop the engine");

    chk_fresh_start: assert property (@(posedge clk) disable iff (rst)
        conv.go |=> dac_code == '0)
        else $error("launch did not clear the trial code");

    // Busy must cover every launch, whatever order power and start took
    chk_busy_running: assert property (@(posedge clk) disable iff (rst)
        conv.running |-> conversion_busy_n)
        else $error("busy low while converting");

    chk_busy_hold: assert property (@(posedge clk) disable iff (rst)
        !conversion_busy_n && !start_rise && !conv.go |=> !conversion_busy_n)
        else $error("busy rose without a start");

    chk_busy_read: assert property (@(posedge clk) disable iff (rst)
        reg_re && reg_addr == OFS_RUN_CTRL
            |=> reg_rdata[BUSY_BIT] == $past(conversion_busy_n))
        else $error("busy flag read back wrong");

    chk_result_hold: assert property (@(posedge clk) disable iff (rst)
        !conv.done |=> $stable(result_low_byte) && $stable(result_high_byte))
        else $error("result bytes changed without completion");

    chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
        wr_irq && !reg_wdata[FLAG_BIT] && !conv.done |=> !converter_irq_flag)
        else $error("software clear of interrupt flag lost");

    chk_irq_follow: assert property (@(posedge clk) disable iff (rst)
        converter_irq_flag && converter_irq_enable && multifunction_irq_enable
            && global_irq_enable && !stack_full |=> irq_request)
        else $error("interrupt not raised with all enables set");

    // Write-through checks catch a field landing on the wrong bit
    chk_channel_write: assert property (@(posedge clk) disable iff (rst)
        wr_run |=> channel_select == $past(reg_wdata[3:0]))
        else $error("channel select not updated");

    chk_pin_write: assert property (@(posedge clk) disable iff (rst)
        wr_pin |=> pin_analog_enable == $past(reg_wdata))
        else $error("pin enables not updated");

    chk_divider_write: assert property (@(posedge clk) disable iff (rst)
        wr_clk |=> clock_divider_select == $past(reg_wdata[DIV_LSB +: 3]))
        else $error("divider select not updated");

    chk_ref_write: assert property (@(posedge clk) disable iff (rst)
        wr_clk |=> reference_select == $past(reg_wdata[REF_BIT]))
        else $error("reference select not updated");

    chk_power_write: assert property (@(posedge clk) disable iff (rst)
        wr_clk |=> converter_power_off == $past(reg_wdata[PWR_OFF_BIT]))
        else $error("power-off bit not updated");
endmodule : acc_top

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import acc_pkg::*;
    // ****************
    // Signals
    // ****************
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0]        reg_wdata;
    logic              reg_we;
    logic              reg_re;
    logic [7:0]        reg_rdata;
    logic              cmp_above;
    logic [RES_W-1:0]  dac_code;
    logic [3:0]        channel_select;
    logic              reference_select;
    logic              converter_power_off;
    logic [7:0]        pin_analog_enable;
    logic              stack_full;
    logic              irq_request;
    logic [RES_W-1:0]  target;
    int                failures;
    int                checks_done;

    acc_top acc_top_inst (
        .clk                 (clk),
        .rst                 (rst),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_we              (reg_we),
        .reg_re              (reg_re),
        .reg_rdata           (reg_rdata),
        .cmp_above           (cmp_above),
        .dac_code            (dac_code),
        .channel_select      (channel_select),
        .reference_select    (reference_select),
        .converter_power_off (converter_power_off),
        .pin_analog_enable   (pin_analog_enable),
        .stack_full          (stack_full),
        .irq_request         (irq_request)
    );

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Comparator lags the DAC by one cycle, so values need ratio of 2 up
    always @(posedge clk) cmp_above <= (target >= dac_code);

    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                       input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a,
                          input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re   <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask : rd_chk

    function automatic int ratio_of(input logic [2:0] c);
        case (c)
            3'h4: return 1;
            3'h0: return 2;
            3'h5: return 4;
            3'h1: return 8;
            3'h6: return 16;
            default: return 32;
        endcase
    endfunction : ratio_of

    task automatic conv(input logic [2:0] dv, input logic [3:0] ch,
                        input logic [11:0] tg);
        int n;
        int r;
        logic ok;
        r = ratio_of(dv);
        target <= tg;
        wr(OFS_CLK_CTRL, {5'h00, dv});
        wr(OFS_IRQ_CTRL, 8'h0e);
        wr(OFS_RUN_CTRL, {4'h8, ch});
        wr(OFS_RUN_CTRL, {4'h0, ch});
        reg_re   <= 1'b1;
        reg_addr <= OFS_RUN_CTRL;
        n = 0;
        while (n < 16 * r + 8) begin
            @(posedge clk);
            #1;
            n++;
            if (reg_rdata[BUSY_BIT] === 1'b0) break;
        end
        @(posedge clk);
        reg_re <= 1'b0;
        ok = (n >= 16 * r) && (n <= 16 * r + 3);
        chk(channel_select, ch, "channel");
        chk({11'h0, ok}, 12'h001, "conversion time");
        if (r > 1) begin
            rd_chk(OFS_RES_LO, tg[7:0], "result low");
            rd_chk(OFS_RES_HI, {4'h0, tg[11:8]}, "result high");
        end
        rd_chk(OFS_IRQ_CTRL, 8'h0f, "flag");
        chk(irq_request, 12'h001, "irq");
    endtask : conv

    task automatic test_done;
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // ****************
    // Main sequence
    // ****************
    initial begin
        rst        = 1'b1;
        reg_addr   = '0;
        reg_wdata  = 8'h00;
        reg_we     = 1'b0;
        reg_re     = 1'b0;
        stack_full = 1'b0;
        target     = 12'h000;
        cmp_above  = 1'b0;
        failures   = 0;
        checks_done = 0;
        void'($urandom(32'hb3045e49));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_chk(OFS_CLK_CTRL, 8'h80, "clock ctrl reset");
        rd_chk(OFS_RUN_CTRL, 8'h40, "run ctrl reset");
        rd_chk(OFS_PIN_CFG, 8'h00, "pin cfg reset");
        rd_chk(OFS_IRQ_CTRL, 8'h00, "irq ctrl reset");
        rd_chk(3'h6, 8'h00, "unmapped 6");
        rd_chk(3'h7, 8'h00, "unmapped 7");
        chk(converter_power_off, 12'h001, "power off reset");
        // Start while powered down must do nothing
        wr(OFS_RUN_CTRL, 8'h83);
        wr(OFS_RUN_CTRL, 8'h03);
        repeat (40) @(posedge clk);
        rd_chk(OFS_IRQ_CTRL, 8'h00, "flag while off");
        chk(dac_code, 12'h000, "dac while off");
        chk(channel_select, 12'h003, "channel 3");
        wr(OFS_CLK_CTRL, 8'h01);
        rd_chk(OFS_CLK_CTRL, 8'h01, "clock ctrl 01");
        chk(converter_power_off, 12'h000, "powered");
        chk(reference_select, 12'h000, "supply ref");
        wr(OFS_PIN_CFG, 8'hff);
        rd_chk(OFS_PIN_CFG, 8'hff, "pin cfg");
        chk(pin_analog_enable, 12'h0ff, "pins analog");
        wr(OFS_CLK_CTRL, 8'h08);
        rd_chk(OFS_CLK_CTRL, 8'h08, "ref select");
        chk(reference_select, 12'h001, "external ref");
        // Corner codes, then every divider code with random input
        conv(3'h1, 4'h3, 12'h000);
        conv(3'h2, 4'hf, 12'hfff);
        for (int i = 0; i < 8; i++) begin
            conv(3'(i), 4'($urandom), 12'($urandom));
        end
        // Each enable alone masks the request
        for (int b = 1; b < 4; b++) begin
            wr(OFS_IRQ_CTRL, 8'h0f ^ (8'h01 << b));
            rd_chk(OFS_IRQ_CTRL, 8'h0f ^ (8'h01 << b), "mask");
            chk(irq_request, 12'h000, "masked irq");
        end
        wr(OFS_IRQ_CTRL, 8'h0f);
        rd_chk(OFS_IRQ_CTRL, 8'h0f, "unmask");
        chk(irq_request, 12'h001, "irq again");
        @(posedge clk);
        stack_full <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(irq_request, 12'h000, "stack full");
        @(posedge clk);
        stack_full <= 1'b0;
        wr(OFS_IRQ_CTRL, 8'h0e);
        rd_chk(OFS_IRQ_CTRL, 8'h0e, "flag clear");
        chk(irq_request, 12'h000, "irq cleared");
        // Power off in mid-run abandons the conversion
        wr(OFS_CLK_CTRL, 8'h06);
        wr(OFS_RUN_CTRL, 8'h83);
        wr(OFS_RUN_CTRL, 8'h03);
        repeat (60) @(posedge clk);
        wr(OFS_CLK_CTRL, 8'h86);
        repeat (300) @(posedge clk);
        rd_chk(OFS_IRQ_CTRL, 8'h0e, "no flag after off");
        chk(dac_code, 12'h000, "dac off");
        // A rise mid-run aborts; the next fall starts afresh
        wr(OFS_CLK_CTRL, 8'h06);
        wr(OFS_RUN_CTRL, 8'h83);
        wr(OFS_RUN_CTRL, 8'h03);
        repeat (60) @(posedge clk);
        wr(OFS_RUN_CTRL, 8'h83);
        rd_chk(OFS_RUN_CTRL, 8'hc3, "busy after rise");
        chk(dac_code, 12'h000, "dac after rise");
        conv(3'h6, 4'h3, 12'($urandom));
        // Rise while off, fall once powered: busy must still rise
        wr(OFS_CLK_CTRL, 8'h86);
        wr(OFS_RUN_CTRL, 8'h83);
        wr(OFS_CLK_CTRL, 8'h06);
        wr(OFS_RUN_CTRL, 8'h03);
        rd_chk(OFS_RUN_CTRL, 8'h43, "busy after late launch");
        test_done;
    end

    // Bounded run: the longest sequence needs well under this
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        $display("Error %0t: watchdog expired", $time);
        test_done;
    end
endmodule : testbench
